// file: logic/iesv_pkg.sv
package iesv_pkg;
  localparam int IESV_NUM_TYPES = 19;
  localparam logic [11:0] IESV_STATUS_OFFSET = 12'h484;
  localparam logic [11:0] IESV_MASK_OFFSET = 12'h488;
  localparam logic [11:0] IESV_SEVERITY_OFFSET = 12'h48c;
  localparam logic [11:0] IESV_TEST_OFFSET = 12'h490;
  localparam logic [11:0] IESV_IRQ_STATUS_OFFSET = 12'h4a0;
  localparam logic [11:0] IESV_IRQ_CLEAR_OFFSET = 12'h4a4;
  localparam logic [11:0] IESV_IRQ_ENABLE_OFFSET = 12'h4a8;
  localparam logic [18:0] IESV_IMPLEMENTED = 19'h7fff7;
  localparam logic [18:0] IESV_SEVERITY_RESET = 19'h4d511;
  localparam logic [18:0] IESV_MASK_RESET = 19'h00000;
  localparam int IESV_IRQ_UNCORR_BIT = 0;
  localparam int IESV_IRQ_CORR_BIT = 1;
  localparam int IESV_IRQ_STATUS_BIT = 2;
  localparam logic [2:0] IESV_IRQ_RESET = 3'h0;
  localparam logic [31:0] IESV_READ_UNMAPPED = 32'h00000000;
endpackage

// file: logic/iesv_sticky_reg.sv
`timescale 1ns/1ns
module iesv_sticky_reg
  import iesv_pkg::*;
#(
  parameter logic [18:0] RESET_VALUE = 19'h00000
) (
  input wire logic core_clk_i,
  input wire logic sticky_rst_i,
  input wire logic wr_en_i,
  input wire logic [18:0] wr_data_i,
  output logic [18:0] value_o
);
  logic [18:0] value_q;

  always_ff @(posedge core_clk_i or posedge sticky_rst_i) begin
    if (sticky_rst_i) begin
      value_q <= RESET_VALUE;
    end else if (wr_en_i) begin
      value_q <= wr_data_i & IESV_IMPLEMENTED;
    end
  end

  assign value_o = value_q;
endmodule

// file: logic/iesv_irq.sv
`timescale 1ns/1ns
module iesv_irq
  import iesv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] event_i,
  input wire logic clear_en_i,
  input wire logic [2:0] clear_i,
  input wire logic enable_en_i,
  input wire logic [2:0] enable_i,
  output logic [2:0] status_o,
  output logic [2:0] enable_o,
  output logic irq_o
);
  logic [2:0] status_q;
  logic [2:0] enable_q;
  logic irq_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      status_q <= IESV_IRQ_RESET;
    end else begin
      status_q <= (status_q & ~(clear_en_i ? clear_i : 3'h0)) | event_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      enable_q <= IESV_IRQ_RESET;
    end else if (enable_en_i) begin
      enable_q <= enable_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(((status_q & ~(clear_en_i ? clear_i : 3'h0)) | event_i) &
               (enable_en_i ? enable_i : enable_q));
    end
  end

  assign status_o = status_q;
  assign enable_o = enable_q;
  assign irq_o = irq_q;
endmodule

// file: logic/iesv_top.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
module iesv_top
  import iesv_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic sticky_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [18:0] error_event_i,
  output logic [31:0] reg_rdata_o,
  output logic uncorrectable_err_o,
  output logic correctable_err_o,
  output logic [18:0] uncorr_vector_o,
  output logic [18:0] corr_vector_o,
  output logic irq_o
);
  logic [18:0] severity;
  logic [18:0] mask;
  logic [18:0] status_q;
  logic [18:0] pending;
  logic [18:0] uncorr_vec_q;
  logic [18:0] corr_vec_q;
  logic uncorr_q;
  logic corr_q;
  logic [31:0] rdata_q;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic [2:0] irq_event;
  logic [18:0] test_set;
  logic [18:0] status_clr;

  function automatic logic wr_hit(input logic [11:0] a, input logic [11:0] off,
                                  input logic wr);
    wr_hit = wr && (a == off);
  endfunction

  // Severity, software sticky
  iesv_sticky_reg #(
    .RESET_VALUE(IESV_SEVERITY_RESET)
  ) u_severity (
    .core_clk_i(core_clk_i),
    .sticky_rst_i(sticky_rst_i),
    .wr_en_i(wr_hit(reg_addr_i, IESV_SEVERITY_OFFSET, reg_wr_i)),
    .wr_data_i(reg_wdata_i[18:0]),
    .value_o(severity)
  );

  // Mask, software sticky
  iesv_sticky_reg #(
    .RESET_VALUE(IESV_MASK_RESET)
  ) u_mask (
    .core_clk_i(core_clk_i),
    .sticky_rst_i(sticky_rst_i),
    .wr_en_i(wr_hit(reg_addr_i, IESV_MASK_OFFSET, reg_wr_i)),
    .wr_data_i(reg_wdata_i[18:0]),
    .value_o(mask)
  );

  assign test_set = wr_hit(reg_addr_i, IESV_TEST_OFFSET, reg_wr_i) ?
                    (reg_wdata_i[18:0] & IESV_IMPLEMENTED) : 19'h00000;
  assign status_clr = wr_hit(reg_addr_i, IESV_STATUS_OFFSET, reg_wr_i) ?
                      reg_wdata_i[18:0] : 19'h00000;

  // Status, write one to clear, set wins
  always_ff @(posedge core_clk_i or posedge sticky_rst_i) begin
    if (sticky_rst_i) begin
      status_q <= 19'h00000;
    end else begin
      status_q <= ((status_q & ~status_clr) | error_event_i | test_set) &
                  IESV_IMPLEMENTED;
    end
  end

  assign pending = status_q & ~mask;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uncorr_vec_q <= 19'h00000;
      corr_vec_q <= 19'h00000;
    end else begin
      uncorr_vec_q <= pending & severity;
      corr_vec_q <= pending & ~severity;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      uncorr_q <= 1'b0;
      corr_q <= 1'b0;
    end else begin
      uncorr_q <= |(pending & severity);
      corr_q <= |(pending & ~severity);
    end
  end

  assign irq_event[IESV_IRQ_UNCORR_BIT] = |(pending & severity);
  assign irq_event[IESV_IRQ_CORR_BIT] = |(pending & ~severity);
  assign irq_event[IESV_IRQ_STATUS_BIT] = |((error_event_i | test_set) & IESV_IMPLEMENTED);

  iesv_irq u_irq (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .event_i(irq_event),
    .clear_en_i(wr_hit(reg_addr_i, IESV_IRQ_CLEAR_OFFSET, reg_wr_i)),
    .clear_i(reg_wdata_i[2:0]),
    .enable_en_i(wr_hit(reg_addr_i, IESV_IRQ_ENABLE_OFFSET, reg_wr_i)),
    .enable_i(reg_wdata_i[2:0]),
    .status_o(irq_status),
    .enable_o(irq_enable),
    .irq_o(irq_o)
  );

  // Read data one cycle after strobe
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= IESV_READ_UNMAPPED;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        IESV_SEVERITY_OFFSET: rdata_q <= {13'h0000, severity};
        IESV_MASK_OFFSET: rdata_q <= {13'h0000, mask};
        IESV_STATUS_OFFSET: rdata_q <= {13'h0000, status_q};
        IESV_TEST_OFFSET: rdata_q <= IESV_READ_UNMAPPED;
        IESV_IRQ_STATUS_OFFSET: rdata_q <= {29'h00000000, irq_status};
        IESV_IRQ_ENABLE_OFFSET: rdata_q <= {29'h00000000, irq_enable};
        default: rdata_q <= IESV_READ_UNMAPPED;
      endcase
    end else begin
      rdata_q <= IESV_READ_UNMAPPED;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign uncorrectable_err_o = uncorr_q;
  assign correctable_err_o = corr_q;
  assign uncorr_vector_o = uncorr_vec_q;
  assign corr_vector_o = corr_vec_q;

  uncorr_route_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (|(status_q & ~mask & severity)) |=> uncorrectable_err_o)
    else $error("uncorrectable error not reported");

  corr_route_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (|(status_q & ~mask & ~severity)) |=> correctable_err_o)
    else $error("correctable error not reported");

  mask_block_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ((status_q & ~mask) == 19'h00000) |=> !uncorrectable_err_o && !correctable_err_o)
    else $error("masked error reported");

  vector_split_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (uncorr_vector_o & corr_vector_o) == 19'h00000)
    else $error("error reported with both severities");

  severity_reserved_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    severity[3] == 1'b0)
    else $error("reserved severity bit set");

  severity_write_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    wr_hit(reg_addr_i, IESV_SEVERITY_OFFSET, reg_wr_i) |=>
    severity == ($past(reg_wdata_i[18:0]) & IESV_IMPLEMENTED))
    else $error("severity write lost");

  severity_hold_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    $rose(sys_rst_i) |=> $stable(severity))
    else $error("severity lost over plain reset");

  severity_reset_a: assert property (@(posedge core_clk_i)
    $fell(sticky_rst_i) |-> severity == IESV_SEVERITY_RESET)
    else $error("severity reset value wrong");

  // Per-type severity defaults
  for (genvar gi = 0; gi < IESV_NUM_TYPES; gi++) begin : g_sev_reset
    sev_bit_reset_a: assert property (@(posedge core_clk_i)
      $fell(sticky_rst_i) |-> severity[gi] == IESV_SEVERITY_RESET[gi])
      else $error("severity bit reset value wrong");
  end

  test_set_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    wr_hit(reg_addr_i, IESV_TEST_OFFSET, reg_wr_i) |=>
    ((status_q & $past(reg_wdata_i[18:0]) & IESV_IMPLEMENTED) ==
     ($past(reg_wdata_i[18:0]) & IESV_IMPLEMENTED)))
    else $error("test write did not set status");

  test_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IESV_TEST_OFFSET) |=> reg_rdata_o == 32'h00000000)
    else $error("test register read nonzero");

  uncorr_vector_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    1'b1 |=> uncorr_vector_o == ($past(status_q) & ~$past(mask) & $past(severity)))
    else $error("uncorrectable vector wrong");

  corr_vector_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    1'b1 |=> corr_vector_o == ($past(status_q) & ~$past(mask) & ~$past(severity)))
    else $error("correctable vector wrong");

  uncorr_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    uncorrectable_err_o == (|uncorr_vector_o))
    else $error("uncorrectable flag disagrees with vector");

  corr_flag_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    correctable_err_o == (|corr_vector_o))
    else $error("correctable flag disagrees with vector");

  all_masked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (mask == IESV_IMPLEMENTED) |=> !uncorrectable_err_o && !correctable_err_o)
    else $error("fully masked block reported an error");

  mask_keep_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    (wr_hit(reg_addr_i, IESV_MASK_OFFSET, reg_wr_i) && error_event_i == 19'h00000) |=>
    $stable(status_q))
    else $error("mask write changed status");

  mask_write_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    wr_hit(reg_addr_i, IESV_MASK_OFFSET, reg_wr_i) |=>
    mask == ($past(reg_wdata_i[18:0]) & IESV_IMPLEMENTED))
    else $error("mask write lost");

  mask_reserved_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    mask[3] == 1'b0)
    else $error("reserved mask bit set");

  status_reserved_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    status_q[3] == 1'b0)
    else $error("reserved status bit set");

  status_set_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    (|error_event_i) |=> ((status_q & $past(error_event_i) & IESV_IMPLEMENTED) ==
    ($past(error_event_i) & IESV_IMPLEMENTED)))
    else $error("error event did not set status");

  status_clear_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    (wr_hit(reg_addr_i, IESV_STATUS_OFFSET, reg_wr_i) && error_event_i == 19'h00000) |=>
    (status_q & $past(reg_wdata_i[18:0])) == 19'h00000)
    else $error("status clear lost");

  test_keep_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    wr_hit(reg_addr_i, IESV_TEST_OFFSET, reg_wr_i) |=>
    (status_q & $past(status_q)) == $past(status_q))
    else $error("test write cleared status");

  severity_keep_a: assert property (@(posedge core_clk_i) disable iff (sticky_rst_i)
    !wr_hit(reg_addr_i, IESV_SEVERITY_OFFSET, reg_wr_i) |=> $stable(severity))
    else $error("severity changed without write");

  severity_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IESV_SEVERITY_OFFSET) |=>
    reg_rdata_o == {13'h0000, $past(severity)})
    else $error("severity read wrong");

  mask_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IESV_MASK_OFFSET) |=> reg_rdata_o == {13'h0000, $past(mask)})
    else $error("mask read wrong");

  status_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IESV_STATUS_OFFSET) |=>
    reg_rdata_o == {13'h0000, $past(status_q)})
    else $error("status read wrong");

  read_upper_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    reg_rdata_o[31:19] == 13'h0000)
    else $error("reserved read bits set");

  read_idle_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !reg_rd_i |=> reg_rdata_o == IESV_READ_UNMAPPED)
    else $error("read data outside read cycle");

  clear_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (reg_rd_i && reg_addr_i == IESV_IRQ_CLEAR_OFFSET) |=> reg_rdata_o == IESV_READ_UNMAPPED)
    else $error("write-only clear register read nonzero");

  irq_enable_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    wr_hit(reg_addr_i, IESV_IRQ_ENABLE_OFFSET, reg_wr_i) |=>
    irq_enable == $past(reg_wdata_i[2:0]))
    else $error("interrupt enable write lost");

  irq_level_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    irq_o == (|(irq_status & irq_enable)))
    else $error("interrupt level wrong");

  reset_quiet_a: assert property (@(posedge core_clk_i)
    ($past(sys_rst_i) && sys_rst_i) |-> !uncorrectable_err_o && !correctable_err_o &&
    !irq_o && reg_rdata_o == 32'h00000000)
    else $error("outputs active during reset");
endmodule

// file: dv/tb.sv
`timescale 1ns/1ns
module tb
  import iesv_pkg::*;
;
  logic core_clk_i = 0, sys_rst_i = 1, sticky_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [11:0] reg_addr_i = 12'h000;
  logic [31:0] reg_wdata_i = 32'h0, rd_v;
  logic [18:0] error_event_i = 19'h0;
  logic [31:0] reg_rdata_o;
  logic uncorrectable_err_o, correctable_err_o, irq_o;
  logic [18:0] uncorr_vector_o, corr_vector_o;
  int n_errors = 0;
  int n_checks = 0;
  typedef struct {logic [31:0] sev, msk, tst, rb; logic [18:0] u, c;} iesv_row_s;
  iesv_row_s rows [4] = '{
    '{32'h0004d511, 32'h0, 32'h0007fff7, 32'h0004d511, 19'h4d511, 19'h32ae6},
    '{32'h00000000, 32'h00000ff0, 32'h0007fff7, 32'h0, 19'h00000, 19'h7f007},
    '{32'hffffffff, 32'h0007fff7, 32'h0007fff7, 32'h0007fff7, 19'h00000, 19'h00000},
    '{32'h00010000, 32'h0, 32'h00010000, 32'h00010000, 19'h10000, 19'h00000}};
  iesv_top dut_u (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sticky_rst_i(sticky_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .error_event_i(error_event_i), .reg_rdata_o(reg_rdata_o),
    .uncorrectable_err_o(uncorrectable_err_o), .correctable_err_o(correctable_err_o),
    .uncorr_vector_o(uncorr_vector_o), .corr_vector_o(corr_vector_o), .irq_o(irq_o));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    sticky_rst_i <= 1'b0;
    rd(IESV_SEVERITY_OFFSET, rd_v);
    chk(rd_v, 32'h0004d511);
    foreach (rows[i]) begin
      wr(IESV_SEVERITY_OFFSET, rows[i].sev);
      wr(IESV_MASK_OFFSET, rows[i].msk);
      wr(IESV_STATUS_OFFSET, 32'hffffffff);
      wr(IESV_TEST_OFFSET, rows[i].tst);
      settle(3);
      chk({13'h0, uncorr_vector_o}, {13'h0, rows[i].u});
      chk({13'h0, corr_vector_o}, {13'h0, rows[i].c});
      chk({31'h0, uncorrectable_err_o}, {31'h0, |rows[i].u});
      chk({31'h0, correctable_err_o}, {31'h0, |rows[i].c});
      rd(IESV_SEVERITY_OFFSET, rd_v);
      chk(rd_v, rows[i].rb);
      rd(IESV_TEST_OFFSET, rd_v);
      chk(rd_v, 32'h0);
      rd(IESV_STATUS_OFFSET, rd_v);
      chk(rd_v, rows[i].tst & 32'h0007fff7);
    end
    sys_rst_i <= 1'b1;
    settle(2);
    chk({31'h0, uncorrectable_err_o}, 32'h0);
    chk({13'h0, uncorr_vector_o}, 32'h0);
    sys_rst_i <= 1'b0;
    rd(IESV_SEVERITY_OFFSET, rd_v);
    chk(rd_v, 32'h00010000);
    sticky_rst_i <= 1'b1;
    settle(2);
    sticky_rst_i <= 1'b0;
    rd(IESV_SEVERITY_OFFSET, rd_v);
    chk(rd_v, 32'h0004d511);
    wr(IESV_IRQ_ENABLE_OFFSET, 32'h1);
    @(posedge core_clk_i);
    error_event_i <= 19'h08000;
    @(posedge core_clk_i);
    error_event_i <= 19'h0;
    settle(3);
    chk({31'h0, uncorrectable_err_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    rd(IESV_STATUS_OFFSET, rd_v);
    chk(rd_v, 32'h00008000);
    rd(IESV_IRQ_STATUS_OFFSET, rd_v);
    chk(rd_v, 32'h5);
    wr(IESV_IRQ_CLEAR_OFFSET, 32'h7);
    rd(IESV_IRQ_STATUS_OFFSET, rd_v);
    chk(rd_v, 32'h1);
    wr(IESV_IRQ_ENABLE_OFFSET, 32'h0);
    settle(2);
    chk({31'h0, irq_o}, 32'h0);
    wr(IESV_STATUS_OFFSET, 32'hffffffff);
    wr(IESV_IRQ_CLEAR_OFFSET, 32'h7);
    rd(IESV_IRQ_STATUS_OFFSET, rd_v);
    chk(rd_v, 32'h0);
    wr(IESV_TEST_OFFSET, 32'h8);
    rd(IESV_STATUS_OFFSET, rd_v);
    chk(rd_v, 32'h0);
    wr(12'h4fc, 32'hffffffff);
    rd(12'h4fc, rd_v);
    chk(rd_v, 32'h0);
    rd(IESV_SEVERITY_OFFSET, rd_v);
    chk(rd_v, 32'h0004d511);
    end_of_test();
  end
endmodule
